// file: omc_top.sv
// Purpose: operating mode latch and decode, port 3/4 and control line routing
// Assumes: core_clk_i is the E clock; the mode pins are driven while reset is low
// Notes:   the port 3 and port 4 registers live outside; this block steers them and only watches port 2 writes
`timescale 1ns/1ps
module omc_top (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        mode_pin_hi_i,
    input  wire logic        mode_pin_mid_i,
    input  wire logic        mode_pin_lo_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        cpu_access_i,
    input  wire logic        cpu_rd_wr_i,
    input  wire logic [7:0]  cpu_wdata_i,
    input  wire logic        p2_data_wr_i,
    input  wire logic [7:0]  p2_wdata_i,
    input  wire logic        addr_strobe_i,
    input  wire logic [7:0]  p3_dout_i,
    input  wire logic [7:0]  p3_ddr_i,
    input  wire logic [7:0]  p4_dout_i,
    input  wire logic [7:0]  p4_ddr_i,
    input  wire logic        port3_output_strobe_i,
    input  wire logic        ctrl_line_one_i,
    output logic [2:0]       mode_o,
    output logic [2:0]       mode_bits_o,
    output logic             single_chip_o,
    output logic             expanded_nmux_o,
    output logic             expanded_mux_o,
    output logic             ram_en_o,
    output logic             rom_en_o,
    output logic             reg_sel_o,
    output logic             ram_sel_o,
    output logic             rom_sel_o,
    output logic             ext_sel_o,
    output logic             reset_vec_external_o,
    output logic [15:0]      reset_vec_addr_o,
    output logic             p4_ddr_clear_o,
    output logic [7:0]       p3_pin_o,
    output logic [7:0]       p3_oe_o,
    output logic [7:0]       p4_pin_o,
    output logic [7:0]       p4_oe_o,
    output logic [7:0]       p4_addr_lines_o,
    output logic             ctrl_line_one_o,
    output logic             ctrl_line_one_oe_o,
    output logic             ctrl_line_two_o,
    output logic             ctrl_line_two_oe_o,
    output logic             port3_input_strobe_o,
    output logic             external_range_select_o
);
    typedef struct packed {
        logic [2:0]        mode;
        omc_pkg::omc_vec_e vec;
        logic [1:0]        vec_cnt;
        logic              ddr_clr;
    } omc_state_s;

    omc_state_s state;
    omc_state_s next_state;
    logic       switch_req;
    logic       is_sc;
    logic       is_nmux;
    logic       is_mux;
    logic       range_sel;
    logic       wr_access;
    logic       p4_capable;
    logic       p4_force;
    logic [7:0] p4_addr_src;

    assign switch_req = p2_data_wr_i & p2_wdata_i[omc_pkg::P2_SWITCH_BIT];

    always_comb begin
        next_state         = state;
        next_state.ddr_clr = 1'b0;
        if (!rst_b_i) begin
            // sampled every reset cycle; the value at the release is what stays
            next_state.mode    = {mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i};
            next_state.vec     = omc_pkg::VEC_EXTERNAL;
            next_state.vec_cnt = 2'h0;
        end else begin
            if (switch_req && state.mode == omc_pkg::MODE_SC_TEST) begin
                next_state.mode    = omc_pkg::MODE_NMUX;
                next_state.ddr_clr = 1'b1;
            end
            case (state.vec)
                omc_pkg::VEC_EXTERNAL: begin
                    next_state.vec_cnt = state.vec_cnt + 2'h1;
                    if (state.vec_cnt == omc_pkg::VEC_EXT_CYCLES - 2'h1) begin
                        next_state.vec = omc_pkg::VEC_INTERNAL;
                    end
                end
                omc_pkg::VEC_INTERNAL: next_state.vec = omc_pkg::VEC_INTERNAL;
                default:               next_state.vec = omc_pkg::VEC_INTERNAL;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        state <= next_state;
    end

    assign is_sc   = state.mode == omc_pkg::MODE_SC || state.mode == omc_pkg::MODE_SC_TEST;
    assign is_nmux = state.mode == omc_pkg::MODE_NMUX;
    assign is_mux  = ~is_sc & ~is_nmux;

    assign mode_o          = state.mode;
    assign mode_bits_o     = state.mode;
    assign single_chip_o   = is_sc;
    assign expanded_nmux_o = is_nmux;
    assign expanded_mux_o  = is_mux;
    assign p4_ddr_clear_o  = state.ddr_clr;

    // the vector stays external only in mode 0 and only at first
    assign reset_vec_external_o = (state.mode == omc_pkg::MODE_MUX_TEST)
                                & (state.vec == omc_pkg::VEC_EXTERNAL);
    assign reset_vec_addr_o = (state.mode == omc_pkg::MODE_SC_TEST)
                            ? {cpu_addr_i[15:8], omc_pkg::VEC_PAGE_OFS}
                            : omc_pkg::RESET_VECTOR;

    omc_addr_dec u_dec (
        .mode_i      (state.mode),
        .addr_i      (cpu_addr_i),
        .access_i    (cpu_access_i),
        .reg_sel_o   (reg_sel_o),
        .ram_sel_o   (ram_sel_o),
        .rom_sel_o   (rom_sel_o),
        .ext_sel_o   (ext_sel_o),
        .range_sel_o (range_sel),
        .ram_en_o    (ram_en_o),
        .rom_en_o    (rom_en_o)
    );

    assign wr_access = cpu_access_i & ~cpu_rd_wr_i & ext_sel_o;

    // port 3 function
    always_comb begin
        if (is_nmux) begin
            p3_pin_o = cpu_wdata_i;
            p3_oe_o  = {8{wr_access}};
        end else if (is_mux) begin
            // address phase while the strobe is high, data phase after
            p3_pin_o = addr_strobe_i ? cpu_addr_i[7:0] : cpu_wdata_i;
            p3_oe_o  = {8{addr_strobe_i | wr_access}};
        end else begin
            p3_pin_o = p3_dout_i;
            p3_oe_o  = p3_ddr_i;
        end
    end

    // port 4: low address in mode 5, high address in multiplexed modes
    assign p4_capable  = is_nmux | (state.mode == omc_pkg::MODE_MUX_PARTIAL);
    assign p4_force    = is_mux & (state.mode != omc_pkg::MODE_MUX_PARTIAL);
    assign p4_addr_src = is_nmux ? cpu_addr_i[7:0] : cpu_addr_i[15:8];

    for (genvar i = 0; i < 8; i++) begin : g_p4
        omc_p4_line u_line (
            .addr_capable_i (p4_capable),
            .force_addr_i   (p4_force),
            .ddr_i          (p4_ddr_i[i]),
            .dout_i         (p4_dout_i[i]),
            .addr_bit_i     (p4_addr_src[i]),
            .pin_o          (p4_pin_o[i]),
            .oe_o           (p4_oe_o[i]),
            .addr_o         (p4_addr_lines_o[i])
        );
    end

    // control lines; the range select output is active high, line one carries it active low as a chip select in mode 5
    assign external_range_select_o = range_sel;
    assign port3_input_strobe_o    = is_sc & ctrl_line_one_i;
    assign ctrl_line_one_oe_o      = ~is_sc;
    assign ctrl_line_one_o         = is_nmux ? ~range_sel
                                   : (is_mux & addr_strobe_i);
    assign ctrl_line_two_oe_o      = 1'b1;
    assign ctrl_line_two_o         = is_sc ? port3_output_strobe_i
                                   : cpu_rd_wr_i;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_SC_NO_BUS: assert property (is_sc |-> (p4_addr_lines_o == 8'h00) && !ext_sel_o)
        else $error("single chip mode drives an external bus");
    AST_MUX_GROUP: assert property (expanded_mux_o == (mode_o inside {3'h0, 3'h1, 3'h2,
                                    3'h3, 3'h6}))
        else $error("multiplexed group decoded wrongly");
    AST_M4_RAM: assert property (mode_o == 3'h4 && cpu_access_i && cpu_addr_i[7]
                                 && cpu_addr_i[15:5] != 11'h000 |-> ram_sel_o && !rom_sel_o)
        else $error("mode 4 RAM window not answering");
    AST_M4_VEC: assert property (mode_o == 3'h4 |-> reset_vec_addr_o[7:0] == 8'hFE)
        else $error("mode 4 vector offset wrong");
    AST_SWITCH: assert property (mode_o == 3'h4 && p2_data_wr_i && p2_wdata_i[5]
                                 ##1 rst_b_i |-> mode_o == 3'h5 && p4_ddr_clear_o)
        else $error("mode 4 to 5 switch missed");
    AST_HOLD: assert property (mode_o != 3'h4 ##1 rst_b_i |-> $stable(mode_o))
        else $error("latched mode changed without reset");
    AST_NO_SWITCH: assert property (mode_o != 3'h4 && p2_data_wr_i ##1 rst_b_i
                                    |-> !p4_ddr_clear_o)
        else $error("bit 5 write acted outside mode 4");
    AST_RANGE: assert property (mode_o == 3'h5 && cpu_access_i && cpu_addr_i[15:8] == 8'h01
                                |-> external_range_select_o && !ctrl_line_one_o)
        else $error("range select not asserted");
    AST_M0_VEC: assert property ($rose(rst_b_i) && mode_o == 3'h0
                                 |-> reset_vec_external_o [*2] ##1 !reset_vec_external_o)
        else $error("mode 0 vector phase length wrong");
    AST_M7_STROBE: assert property (mode_o == 3'h7 |-> !ctrl_line_one_oe_o
                                    && ctrl_line_two_o == port3_output_strobe_i)
        else $error("mode 7 strobe routing wrong");
    AST_REPORT: assert property ($rose(rst_b_i) |-> mode_bits_o == $past(mode_bits_o))
        else $error("mode bits changed at reset release");

    COV_SWITCH: cover property (mode_o == 3'h4 ##1 mode_o == 3'h5);
    COV_M0_VEC: cover property ($rose(rst_b_i) && reset_vec_external_o);
    COV_RANGE: cover property (external_range_select_o);
    COV_M6_ADDR: cover property (mode_o == 3'h6 && p4_addr_lines_o != 8'h00);
endmodule

// file: omc_pkg.sv
// Purpose: shared constants and types for the operating mode configuration block
// Assumes: 16-bit processor address, 8-bit data, one clock equal to the E cycle
// Notes:   mode numbers follow the binary value of the three latched mode bits
package omc_pkg;
    // mode numbers
    localparam logic [2:0] MODE_MUX_TEST    = 3'h0;
    localparam logic [2:0] MODE_MUX_BOTH    = 3'h1;
    localparam logic [2:0] MODE_MUX_RAM     = 3'h2;
    localparam logic [2:0] MODE_MUX_NONE    = 3'h3;
    localparam logic [2:0] MODE_SC_TEST     = 3'h4;
    localparam logic [2:0] MODE_NMUX        = 3'h5;
    localparam logic [2:0] MODE_MUX_PARTIAL = 3'h6;
    localparam logic [2:0] MODE_SC          = 3'h7;

    // port 2 data register fields
    localparam int         P2_SWITCH_BIT  = 5;
    localparam int         P2_MODE_LSB    = 5;
    localparam int         P2_MODE_MSB    = 7;

    // memory map
    localparam logic [15:0] REG_FIRST      = 16'h0000;
    localparam logic [15:0] REG_LAST       = 16'h001F;
    localparam logic [15:0] RAM_FIRST      = 16'h0080;
    localparam logic [15:0] RAM_LAST       = 16'h00FF;
    localparam logic [7:0]  RAM_PAGE_FIRST = 8'h80;
    localparam logic [15:0] ROM_FIRST      = 16'hF800;
    localparam logic [15:0] EXT_NMUX_FIRST = 16'h0100;
    localparam logic [15:0] EXT_NMUX_LAST  = 16'h01FF;
    localparam logic [15:0] RESET_VECTOR   = 16'hFFFE;
    localparam logic [7:0]  VEC_PAGE_OFS   = 8'hFE;

    // reset vector stays external this many E cycles after reset rises in mode 0
    localparam logic [1:0]  VEC_EXT_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        P3_IO,
        P3_DATA,
        P3_MUX
    } omc_p3_fn_e;

    typedef enum logic {
        VEC_EXTERNAL,
        VEC_INTERNAL
    } omc_vec_e;
endpackage

// file: omc_p4_line.sv
// Purpose: one port 4 line, chooses between user data and an address bit
// Assumes: the direction bit comes from the port 4 direction register
// Notes:   no state; instantiated once per line
`timescale 1ns/1ps
module omc_p4_line (
    input  wire logic addr_capable_i,
    input  wire logic force_addr_i,
    input  wire logic ddr_i,
    input  wire logic dout_i,
    input  wire logic addr_bit_i,
    output logic      pin_o,
    output logic      oe_o,
    output logic      addr_o
);
    logic carries_addr;

    // a line set to output becomes an address line where the mode allows it
    assign carries_addr = force_addr_i | (addr_capable_i & ddr_i);
    assign addr_o       = carries_addr;
    assign pin_o        = carries_addr ? addr_bit_i : dout_i;
    assign oe_o         = carries_addr | ddr_i;
endmodule

// file: omc_addr_dec.sv
// Purpose: memory map decode of internal registers, RAM, ROM and external space
// Assumes: address and access are valid in the same cycle
// Notes:   purely combinational
`timescale 1ns/1ps
module omc_addr_dec (
    input  wire logic [2:0]  mode_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        access_i,
    output logic             reg_sel_o,
    output logic             ram_sel_o,
    output logic             rom_sel_o,
    output logic             ext_sel_o,
    output logic             range_sel_o,
    output logic             ram_en_o,
    output logic             rom_en_o
);
    logic ram_hit;
    logic rom_hit;
    logic reg_hit;
    logic nmux_hit;

    always_comb begin
        ram_en_o = 1'b1;
        rom_en_o = 1'b1;
        case (mode_i)
            omc_pkg::MODE_MUX_NONE: begin
                ram_en_o = 1'b0;
                rom_en_o = 1'b0;
            end
            omc_pkg::MODE_MUX_RAM: rom_en_o = 1'b0;
            omc_pkg::MODE_SC_TEST: rom_en_o = 1'b0;
            default: begin
                ram_en_o = 1'b1;
                rom_en_o = 1'b1;
            end
        endcase
    end

    // test mode 4 mirrors the RAM window into every 256-byte page
    assign ram_hit  = (mode_i == omc_pkg::MODE_SC_TEST)
                    ? (addr_i[7:0] >= omc_pkg::RAM_PAGE_FIRST)
                    : (addr_i >= omc_pkg::RAM_FIRST && addr_i <= omc_pkg::RAM_LAST);
    assign rom_hit  = addr_i >= omc_pkg::ROM_FIRST;
    assign reg_hit  = addr_i <= omc_pkg::REG_LAST;
    assign nmux_hit = addr_i >= omc_pkg::EXT_NMUX_FIRST
                    && addr_i <= omc_pkg::EXT_NMUX_LAST;

    assign reg_sel_o   = access_i & reg_hit;
    assign ram_sel_o   = access_i & ram_en_o & ram_hit & ~reg_hit;
    assign rom_sel_o   = access_i & rom_en_o & rom_hit & ~ram_hit;
    assign range_sel_o = access_i & (mode_i == omc_pkg::MODE_NMUX) & nmux_hit;

    always_comb begin
        case (mode_i)
            omc_pkg::MODE_SC, omc_pkg::MODE_SC_TEST: ext_sel_o = 1'b0;
            omc_pkg::MODE_NMUX:                      ext_sel_o = range_sel_o;
            default: ext_sel_o = access_i & ~reg_sel_o & ~ram_sel_o & ~rom_sel_o;
        endcase
    end
endmodule

// file: omc_ext_dev.sv
// Purpose: far-side device on the non-multiplexed bus, plus the line one strobe source
// Assumes: line one low selects it in mode 5; line two high means read
// Notes:   keeps only the last byte written; enough to see data reach the pins
`timescale 1ns/1ps
module omc_ext_dev (
    input  wire logic       core_clk_i,
    input  wire logic       sel_b_i,
    input  wire logic       sel_oe_i,
    input  wire logic       rd_wr_i,
    input  wire logic [7:0] data_i,
    input  wire logic [7:0] data_oe_i,
    input  wire logic       strobe_i,
    output logic            line_one_o,
    output logic [7:0]      last_wr_o
);
    // shared pin: the driving party wins, otherwise the peripheral strobe shows
    assign line_one_o = sel_oe_i ? sel_b_i : strobe_i;

    // a write is only taken with the whole byte lane driven
    always @(posedge core_clk_i) begin
        if (sel_oe_i && !sel_b_i && !rd_wr_i && data_oe_i == 8'hFF) begin
            last_wr_o <= data_i;
        end
    end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the operating mode block
// Assumes: mode pins held through a 20-cycle reset; inputs change 1 ns after the edge
// Notes:   every mode is visited; the mode 4 to 5 switch is tried in each mode
`timescale 1ns/1ps
module testbench;
    logic        core_clk_i, rst_b_i, mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i;
    logic [15:0] cpu_addr_i, reset_vec_addr_o;
    logic        cpu_access_i, cpu_rd_wr_i, p2_data_wr_i, addr_strobe_i;
    logic        port3_output_strobe_i, ctrl_line_one_i, strobe;
    logic [7:0]  cpu_wdata_i, p2_wdata_i, p3_dout_i, p3_ddr_i, p4_dout_i, p4_ddr_i;
    logic [7:0]  p3_pin_o, p3_oe_o, p4_pin_o, p4_oe_o, p4_addr_lines_o, ext_last;
    logic [2:0]  mode_o, mode_bits_o;
    logic        single_chip_o, expanded_nmux_o, expanded_mux_o, ram_en_o, rom_en_o;
    logic        reg_sel_o, ram_sel_o, rom_sel_o, ext_sel_o, reset_vec_external_o;
    logic        p4_ddr_clear_o, ctrl_line_one_o, ctrl_line_one_oe_o, ctrl_line_two_o;
    logic        ctrl_line_two_oe_o, port3_input_strobe_o, external_range_select_o;
    int          miscompares = 0;
    int          check_count = 0;
    logic [31:0] seed = 32'hA04255D5;

    omc_top omc_top_i (.*);

    omc_ext_dev omc_ext_dev_i (
        .core_clk_i (core_clk_i),
        .sel_b_i    (ctrl_line_one_o),
        .sel_oe_i   (ctrl_line_one_oe_o),
        .rd_wr_i    (ctrl_line_two_o),
        .data_i     (p3_pin_o),
        .data_oe_i  (p3_oe_o),
        .strobe_i   (strobe),
        .line_one_o (ctrl_line_one_i),
        .last_wr_o  (ext_last)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic step();
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic do_reset(input int m);
        rst_b_i = 1'b0;
        {mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i} = m[2:0];
        repeat (20) step();
        rst_b_i = 1'b1;
    endtask

    task automatic p2_write(input logic bit5);
        logic [31:0] r;
        r = rnd();
        p2_data_wr_i = 1'b1;
        p2_wdata_i = {r[7:6], bit5, r[4:0]};
        step();
        p2_data_wr_i = 1'b0;
    endtask

    // one random access, biased towards the regions of the memory map
    task automatic check_decode(input int m);
        logic [31:0] r, q;
        logic [15:0] a;
        logic        mux, reg_hit, ram_hit, rom_hit, rng, wr;
        r = rnd();
        q = rnd();
        a = r[15:0];
        case (a[2:0])
            3'h0: a[15:5] = 11'h000;
            3'h1: a[15:7] = 9'h001;
            3'h2: a[15:8] = 8'h01;
            3'h3: a[15:11] = 5'h1F;
            default: ;
        endcase
        cpu_addr_i = a;
        cpu_access_i = 1'b1;
        cpu_rd_wr_i = a[3];
        cpu_wdata_i = r[23:16];
        addr_strobe_i = a[4];
        port3_output_strobe_i = a[5];
        strobe = a[6];
        p3_dout_i = r[31:24];
        p3_ddr_i = q[7:0];
        p4_dout_i = q[15:8];
        p4_ddr_i = q[23:16];
        #1;
        mux = m < 4 || m == 6;
        wr = !a[3];
        reg_hit = a <= 16'h001F;
        ram_hit = !reg_hit && ((m == 4) ? a[7] : (m != 3 && a[15:7] == 9'h001));
        rom_hit = !(m inside {2, 3, 4}) && a >= 16'hF800;
        rng = m == 5 && a[15:8] == 8'h01;
        check("reg_sel", reg_sel_o, reg_hit);
        check("ram_sel", ram_sel_o, ram_hit);
        check("rom_sel", rom_sel_o, rom_hit);
        check("ram_en", ram_en_o, m != 3);
        check("rom_en", rom_en_o, !(m inside {2, 3, 4}));
        check("vec_addr", reset_vec_addr_o, (m == 4) ? {a[15:8], 8'hFE} : 16'hFFFE);
        check("range_sel", external_range_select_o, rng);
        check("kind", {single_chip_o, expanded_nmux_o, expanded_mux_o}, {m == 4 || m == 7, m == 5, mux});
        check("line_two_oe", ctrl_line_two_oe_o, 1'b1);
        if (m == 4 || m == 7) begin
            check("p3_oe", p3_oe_o, p3_ddr_i);
            check("p3_pin", p3_pin_o & p3_ddr_i, p3_dout_i & p3_ddr_i);
            check("p4_oe", p4_oe_o, p4_ddr_i);
            check("p4_pin", p4_pin_o & p4_ddr_i, p4_dout_i & p4_ddr_i);
            check("ext_sel", ext_sel_o, 1'b0);
            check("p4_lines", p4_addr_lines_o, 8'h00);
            check("line_one_oe", ctrl_line_one_oe_o, 1'b0);
            check("in_strobe", port3_input_strobe_o, strobe);
            check("out_strobe", ctrl_line_two_o, port3_output_strobe_i);
        end else if (m == 5) begin
            check("p4_oe", p4_oe_o, p4_ddr_i);
            check("p4_addr", p4_pin_o & p4_ddr_i, a[7:0] & p4_ddr_i);
            check("p4_lines", p4_addr_lines_o, p4_ddr_i);
            check("ext_sel", ext_sel_o, rng);
            check("line_one", {ctrl_line_one_oe_o, ctrl_line_one_o}, {1'b1, !rng});
            check("line_two", ctrl_line_two_o, cpu_rd_wr_i);
            check("p3_oe", p3_oe_o, (rng && wr) ? 8'hFF : 8'h00);
            if (rng && wr) begin
                step();
                check("ext_wr", ext_last, cpu_wdata_i);
            end
        end else begin
            check("line_one", ctrl_line_one_o, addr_strobe_i);
            check("line_two", ctrl_line_two_o, cpu_rd_wr_i);
            check("p4_oe", p4_oe_o, (m == 6) ? p4_ddr_i : 8'hFF);
            check("p4_addr", p4_pin_o & p4_oe_o, a[15:8] & p4_oe_o);
            check("p4_lines", p4_addr_lines_o, (m == 6) ? p4_ddr_i : 8'hFF);
            if (addr_strobe_i) check("p3_addr", p3_pin_o, a[7:0]);
        end
        step();
    endtask

    initial begin
        {rst_b_i, mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i, cpu_addr_i, cpu_access_i} = '0;
        {cpu_rd_wr_i, cpu_wdata_i, p2_data_wr_i, p2_wdata_i, addr_strobe_i, strobe} = '0;
        {p3_dout_i, p3_ddr_i, p4_dout_i, p4_ddr_i, port3_output_strobe_i} = '0;
        for (int m = 0; m < 8; m++) begin
            do_reset(m);
            check("vec_ext", reset_vec_external_o, m == 0);
            step();
            check("vec_ext", reset_vec_external_o, m == 0);
            step();
            check("vec_ext", reset_vec_external_o, 1'b0);
            check("mode", {mode_o, mode_bits_o}, {m[2:0], m[2:0]});
            // pins moving after release must not disturb the latched mode
            {mode_pin_hi_i, mode_pin_mid_i, mode_pin_lo_i} = ~m[2:0];
            repeat (40) check_decode(m);
            p2_write(1'b0);
            check("mode", mode_o, m[2:0]);
            p2_write(1'b1);
            check("mode_sw", mode_o, (m == 4) ? 3'h5 : m[2:0]);
            check("ddr_clear", p4_ddr_clear_o, m == 4);
            step();
            check("ddr_clear", p4_ddr_clear_o, 1'b0);
            if (m == 4) repeat (30) check_decode(5);
            p2_write(1'b1);
            check("mode_again", mode_o, (m == 4) ? 3'h5 : m[2:0]);
            check("ddr_clear", p4_ddr_clear_o, 1'b0);
        end
        finish_test();
    end

    // the full run needs roughly 560 cycles; allow a wide margin
    initial begin
        #(100 * 6000);
        miscompares++;
        finish_test();
    end
endmodule
